// ### pmsbr_regs.sv
// control and status register bank: battery monitor, thermal
// interrupt, voltage and control of three switching regulators
// register port is a simple strobe port behind the serial interface;
// analog status levels are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "pmsbr_cfg.svh"
module pmsbr_regs (
    // clock, reset, enable
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    // analog status
    input  wire logic       bat_below_in,
    input  wire logic       thermal_in,
    input  wire logic       voltage_select_pin,
    input  wire logic [2:0] pgood_in,
    input  wire logic [2:0] fault_in,
    // regulator controls
    output var  logic [3:0] battery_threshold_code,
    output var  logic [5:0] buck_one_vcode,
    output var  logic [5:0] buck_two_vcode,
    output var  logic [5:0] buck_three_vcode,
    output var  logic [2:0] buck_en,
    output var  logic [2:0] buck_phase,
    // open-drain interrupt
    output var  logic       irq_out,
    output var  logic       irq_oe
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta_r;
    logic rst_n_s;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_n_s    <= 1'b0;
        end else if (ce) begin
            rst_meta_r <= 1'b1;
            rst_n_s    <= rst_meta_r;
        end
    end

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [8:0] pins_s;
    logic       bat_live;
    logic       thr_live;
    logic       voltage_select_pin_s;
    logic [2:0] pg_s;
    logic [2:0] flt_s;

    pmsbr_sync #(.W(9)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n_s),
        .ce       (ce),
        .d        ({fault_in, pgood_in, voltage_select_pin, thermal_in, bat_below_in}),
        .q        (pins_s)
    );

    assign bat_live = pins_s[0];
    assign thr_live = pins_s[1];
    assign voltage_select_pin_s   = pins_s[2];
    assign pg_s     = pins_s[5:3];
    assign flt_s    = pins_s[8:6];

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire hit_bat = reg_addr == `PMSBR_OFS_BAT;
    wire hit_thr = reg_addr == `PMSBR_OFS_THR;
    wire hit_v1  = reg_addr == `PMSBR_OFS_V1;
    wire hit_v2  = reg_addr == `PMSBR_OFS_V2;
    wire hit_v2b = reg_addr == `PMSBR_OFS_V2B;
    wire hit_v3  = reg_addr == `PMSBR_OFS_V3;
    wire hit_c1  = reg_addr == `PMSBR_OFS_C1;
    wire hit_c2  = reg_addr == `PMSBR_OFS_C2;
    wire hit_c3  = reg_addr == `PMSBR_OFS_C3;
    wire wr_bat  = reg_wr & hit_bat;
    wire wr_thr  = reg_wr & hit_thr;
    wire rd_bat  = reg_rd & hit_bat;
    wire rd_thr  = reg_rd & hit_thr;

    // ----------------------------------------
    // system registers
    // ----------------------------------------
    logic       bat_unmask_r;
    logic       bat_flag_r;
    logic       bat_rsvd_r;
    logic [3:0] bat_code_r;
    logic       bat_prev_r;
    logic       thr_unmask_r;
    logic       thr_flag_r;
    logic [5:0] thr_rsvd_r;
    logic       thr_prev_r;

    // flag sets on the rising comparator edge; a set wins over read-clear
    wire bat_set      = bat_live & ~bat_prev_r;
    wire thr_set      = thr_live & ~thr_prev_r;
    wire bat_flag_nxt = bat_set | (bat_flag_r & ~rd_bat);
    wire thr_flag_nxt = thr_set | (thr_flag_r & ~rd_thr);

    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            bat_unmask_r <= 1'b0;
            bat_rsvd_r   <= 1'b0;
            bat_code_r   <= `PMSBR_RST_CODE;
        end else if (ce && wr_bat) begin
            bat_unmask_r <= reg_wdata[`PMSBR_B_UNMASK];
            bat_rsvd_r   <= reg_wdata[`PMSBR_B_RSVD];
            bat_code_r   <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            thr_unmask_r <= 1'b0;
            thr_rsvd_r   <= `PMSBR_RST_RSVD;
        end else if (ce && wr_thr) begin
            thr_unmask_r <= reg_wdata[`PMSBR_B_UNMASK];
            thr_rsvd_r   <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            bat_flag_r <= 1'b0;
            thr_flag_r <= 1'b0;
            bat_prev_r <= 1'b0;
            thr_prev_r <= 1'b0;
        end else if (ce) begin
            bat_flag_r <= bat_flag_nxt;
            thr_flag_r <= thr_flag_nxt;
            bat_prev_r <= bat_live;
            thr_prev_r <= thr_live;
        end
    end

    assign battery_threshold_code = bat_code_r;

    // ----------------------------------------
    // voltage codes
    // ----------------------------------------
    logic [5:0] vpri_r [3];
    logic [5:0] vsec_r;
    logic [2:0] vwr;

    assign vwr = {reg_wr & hit_v3, reg_wr & hit_v2, reg_wr & hit_v1};

    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            for (int i = 0; i < 3; i++) begin
                vpri_r[i] <= `PMSBR_RST_V;
            end
            vsec_r <= `PMSBR_RST_V;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                if (vwr[i]) begin
                    vpri_r[i] <= reg_wdata[5:0];
                end
            end
            if (reg_wr && hit_v2b) begin
                vsec_r <= reg_wdata[5:0];
            end
        end
    end

    wire [5:0] buck_two_sel = voltage_select_pin_s ? vsec_r : vpri_r[1];

    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            buck_one_vcode   <= `PMSBR_RST_V;
            buck_two_vcode   <= `PMSBR_RST_V;
            buck_three_vcode <= `PMSBR_RST_V;
        end else if (ce) begin
            buck_one_vcode   <= vpri_r[0];
            buck_two_vcode   <= buck_two_sel;
            buck_three_vcode <= vpri_r[2];
        end
    end

    // ----------------------------------------
    // regulator control slices
    // ----------------------------------------
    pmsbr_buck_if bif [3] ();
    wire [2:0] cwr = {reg_wr & hit_c3, reg_wr & hit_c2, reg_wr & hit_c1};
    logic [2:0] fault_req;
    logic [7:0] ctrl_rd [3];

    for (genvar g = 0; g < 3; g++) begin : g_buck
        assign bif[g].ctrl_wr = cwr[g];
        assign bif[g].wdata   = reg_wdata;
        assign bif[g].pgood   = pg_s[g];
        assign bif[g].fault   = flt_s[g];
        assign fault_req[g]   = bif[g].fault_req;
        assign ctrl_rd[g]     = bif[g].ctrl_rd;
        assign buck_en[g]     = bif[g].en;
        assign buck_phase[g]  = bif[g].phase;
        pmsbr_buck_ctrl u_buck (
            .core_clk (core_clk),
            .rst_n    (rst_n_s),
            .ce       (ce),
            .bus      (bif[g].buck)
        );
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    wire [7:0] bat_rd = {bat_unmask_r, bat_flag_r, bat_live, bat_rsvd_r, bat_code_r};
    wire [7:0] thr_rd = {thr_unmask_r, thr_flag_r, thr_rsvd_r};
    wire [7:0] rd_mux =
        hit_bat ? bat_rd :
        hit_thr ? thr_rd :
        hit_v1  ? {`PMSBR_ZERO2, vpri_r[0]} :
        hit_v2  ? {`PMSBR_ZERO2, vpri_r[1]} :
        hit_v2b ? {`PMSBR_ZERO2, vsec_r}    :
        hit_v3  ? {`PMSBR_ZERO2, vpri_r[2]} :
        hit_c1  ? ctrl_rd[0] :
        hit_c2  ? ctrl_rd[1] :
        hit_c3  ? ctrl_rd[2] : `PMSBR_RST_BYTE;

    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            reg_rdata <= `PMSBR_RST_BYTE;
        end else if (ce && reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // ----------------------------------------
    // interrupt
    // ----------------------------------------
    wire irq_any = (bat_flag_r & bat_unmask_r) | (thr_flag_r & thr_unmask_r)
                 | (|fault_req);

    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            irq_oe  <= 1'b0;
            irq_out <= 1'b0;
        end else if (ce) begin
            irq_oe  <= irq_any;
            irq_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_s);

    property p_bat_unmask;
        ce && bat_flag_r && bat_unmask_r |=> irq_oe;
    endproperty
    a_bat_unmask: assert property (p_bat_unmask) else $error("battery irq missing");

    property p_bat_flag;
        ce && bat_live && !bat_prev_r |=> bat_flag_r;
    endproperty
    a_bat_flag: assert property (p_bat_flag) else $error("battery flag not set");

    property p_bat_live;
        ce && rd_bat |=> reg_rdata[`PMSBR_B_LIVE] == $past(bat_live);
    endproperty
    a_bat_live: assert property (p_bat_live) else $error("live bit wrong");

    property p_bat_code;
        ce && wr_bat |=> battery_threshold_code == $past(reg_wdata[3:0]);
    endproperty
    a_bat_code: assert property (p_bat_code) else $error("threshold code wrong");

    property p_thr_unmask;
        ce && thr_flag_r && thr_unmask_r |=> irq_oe;
    endproperty
    a_thr_unmask: assert property (p_thr_unmask) else $error("thermal irq missing");

    property p_thr_flag;
        ce && thr_live && !thr_prev_r |=> thr_flag_r;
    endproperty
    a_thr_flag: assert property (p_thr_flag) else $error("thermal flag not set");

    property p_v_rsvd;
        ce && reg_rd && (hit_v1 || hit_v2 || hit_v3) |=> reg_rdata[7:6] == `PMSBR_ZERO2;
    endproperty
    a_v_rsvd: assert property (p_v_rsvd) else $error("reserved bits set");

    property p_voltage_select_pin_lo;
        ce && !voltage_select_pin_s |=> buck_two_vcode == $past(vpri_r[1]);
    endproperty
    a_voltage_select_pin_lo: assert property (p_voltage_select_pin_lo) else $error("primary code not applied");

    property p_voltage_select_pin_hi;
        ce && voltage_select_pin_s |=> buck_two_vcode == $past(vsec_r);
    endproperty
    a_voltage_select_pin_hi: assert property (p_voltage_select_pin_hi) else $error("secondary code not applied");

    property p_pgood;
        ce && reg_rd && hit_c1 |=> reg_rdata[`PMSBR_B_PGOOD] == $past(pg_s[0]);
    endproperty
    a_pgood: assert property (p_pgood) else $error("power-good bit wrong");

    property p_irq_rel;
        ce && !irq_any |=> !irq_oe;
    endproperty
    a_irq_rel: assert property (p_irq_rel) else $error("irq not released");

    c_bat_irq: cover property (bat_flag_r && bat_unmask_r ##1 irq_oe);
    c_thr_clr: cover property (thr_flag_r && rd_thr ##1 !thr_flag_r);
    c_voltage_select_pin_hi: cover property (voltage_select_pin_s && buck_two_vcode != buck_one_vcode);
endmodule : pmsbr_regs
`default_nettype wire

// ### pmsbr_cfg.svh
// offsets, field positions and reset values of the register bank
// included by the bank (pmsbr_regs) and by each regulator control slice (pmsbr_buck_ctrl)
//
// Behaviour
// - battery register bit 7 set lets low-battery flag raise the interrupt
// - battery register bit 6 reads 1 while a low-battery interrupt is pending
// - battery register bit 5 reads live comparator, 1 when battery below threshold
// - battery register bits 3:0 hold threshold code driven to comparator
// - thermal register bit 7 set lets thermal flag raise the interrupt
// - thermal register bit 6 reads 1 while a thermal interrupt is pending
// - primary voltage code in bits 5:0, bits 7:6 read zero
// - dual-code regulator applies primary code while select pin is low
// - dual-code regulator applies secondary code while select pin is high
// - control bit 7 turns the regulator on or off
// - control bit 2 set runs regulator 180 degrees out of phase
// - control bit 1 set lets the regulator fault raise the interrupt
// - control bit 0 reads 1 while output is above power-good threshold
`ifndef PMSBR_CFG_SVH
`define PMSBR_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMSBR_OFS_BAT   8'h00
`define PMSBR_OFS_THR   8'h01
`define PMSBR_OFS_V1    8'h10
`define PMSBR_OFS_C1    8'h12
`define PMSBR_OFS_V2    8'h20
`define PMSBR_OFS_V2B   8'h21
`define PMSBR_OFS_C2    8'h22
`define PMSBR_OFS_V3    8'h30
`define PMSBR_OFS_C3    8'h32

// ----------------------------------------
// field positions
// ----------------------------------------
`define PMSBR_B_UNMASK  7
`define PMSBR_B_FLAG    6
`define PMSBR_B_LIVE    5
`define PMSBR_B_RSVD    4
`define PMSBR_B_EN      7
`define PMSBR_B_PHASE   2
`define PMSBR_B_FLTEN   1
`define PMSBR_B_PGOOD   0

// ----------------------------------------
// reset values and fillers
// ----------------------------------------
`define PMSBR_RST_BYTE  8'h00
`define PMSBR_RST_CODE  4'h0
`define PMSBR_RST_V     6'h00
`define PMSBR_RST_RSVD  6'h00
`define PMSBR_ZERO2     2'h0
`define PMSBR_ZERO4     4'h0

`endif

// ### pmsbr_pkg.sv
// shared types of the register bank
// no assumptions beyond a SystemVerilog compiler
package pmsbr_pkg;
    typedef logic [7:0] pmsbr_byte_type;
    typedef logic [5:0] pmsbr_vcode_type;
    typedef logic [3:0] pmsbr_thr_type;
endpackage : pmsbr_pkg

// ### pmsbr_buck_if.sv
// carrier between the bank and one regulator control slice
// driven from the bank's clock domain only
`timescale 1ns/1ps
`default_nettype none
interface pmsbr_buck_if;
    logic                    ctrl_wr;
    pmsbr_pkg::pmsbr_byte_type wdata;
    logic                    pgood;
    logic                    fault;
    pmsbr_pkg::pmsbr_byte_type ctrl_rd;
    logic                    fault_req;
    logic                    en;
    logic                    phase;
    modport bank (output ctrl_wr, wdata, pgood, fault,
                  input  ctrl_rd, fault_req, en, phase);
    modport buck (input  ctrl_wr, wdata, pgood, fault,
                  output ctrl_rd, fault_req, en, phase);
endinterface : pmsbr_buck_if
`default_nettype wire

// ### pmsbr_sync.sv
// two-stage synchroniser for a vector of pin levels
// inputs are asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module pmsbr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // levels
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : pmsbr_sync
`default_nettype wire

// ### pmsbr_buck_ctrl.sv
// control register of one switching regulator
// pgood and fault arrive already synchronised
`timescale 1ns/1ps
`default_nettype none
`include "pmsbr_cfg.svh"
module pmsbr_buck_ctrl (
    // clock and reset
    input  wire logic  core_clk,
    input  wire logic  rst_n,
    input  wire logic  ce,
    // bank side
    pmsbr_buck_if.buck bus
);
    logic en_r;
    logic phase_r;
    logic flten_r;
    logic fault_req_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r    <= 1'b0;
            phase_r <= 1'b0;
            flten_r <= 1'b0;
        end else if (ce && bus.ctrl_wr) begin
            en_r    <= bus.wdata[`PMSBR_B_EN];
            phase_r <= bus.wdata[`PMSBR_B_PHASE];
            flten_r <= bus.wdata[`PMSBR_B_FLTEN];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_req_r <= 1'b0;
        end else if (ce) begin
            fault_req_r <= bus.fault & flten_r;
        end
    end

    assign bus.en        = en_r;
    assign bus.phase     = phase_r;
    assign bus.fault_req = fault_req_r;
    assign bus.ctrl_rd   = {en_r, `PMSBR_ZERO4, phase_r, flten_r, bus.pgood};

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_en_wr;
        @(posedge core_clk) disable iff (!rst_n)
        ce && bus.ctrl_wr |=> en_r == $past(bus.wdata[`PMSBR_B_EN]);
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable not stored");

    property p_phase_wr;
        @(posedge core_clk) disable iff (!rst_n)
        ce && bus.ctrl_wr |=> bus.phase == $past(bus.wdata[`PMSBR_B_PHASE]);
    endproperty
    a_phase_wr: assert property (p_phase_wr) else $error("phase not stored");

    property p_fault_gate;
        @(posedge core_clk) disable iff (!rst_n)
        ce && bus.fault && flten_r |=> fault_req_r;
    endproperty
    a_fault_gate: assert property (p_fault_gate) else $error("fault not raised");

    property p_fault_masked;
        @(posedge core_clk) disable iff (!rst_n)
        ce && !flten_r |=> !fault_req_r;
    endproperty
    a_fault_masked: assert property (p_fault_masked) else $error("masked fault raised");
endmodule : pmsbr_buck_ctrl
`default_nettype wire

// ### pmsbr_host_model.sv
// host processor model: drives the bank's register strobe port
// assumes one access in flight at a time, ce held high by the bench except during one write
`timescale 1ns/1ps
`default_nettype none
module pmsbr_host_model (
    // clock
    input  wire logic       core_clk,
    // register port
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // ----------------------------------------
    // one-cycle write strobe
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        // released data must not keep showing the old byte
        reg_wdata <= ~d;
    endtask : wr

    // ----------------------------------------
    // one-cycle read strobe, data one edge later
    // ----------------------------------------
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        q = reg_rdata;
    endtask : rd
endmodule : pmsbr_host_model
`default_nettype wire

// ### pmic_sys_and_buck_ctrl_regs_tb.sv
// self-checking bench of the register bank
// assumes host model drives the register port, bench drives status pins
`timescale 1ns/1ps
`default_nettype none
module pmic_sys_and_buck_ctrl_regs_tb;
    logic       core_clk;
    logic       nrst;
    logic       ce;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       bat_below_in;
    logic       thermal_in;
    logic       voltage_select_pin;
    logic [2:0] pgood_in;
    logic [2:0] fault_in;
    logic [3:0] thr_code;
    logic [5:0] v1;
    logic [5:0] v2;
    logic [5:0] v3;
    logic [2:0] en;
    logic [2:0] ph;
    logic       irq_out;
    logic       irq_oe;
    int         mismatches;
    int         num_checks;
    logic [7:0] shadow [0:255];
    logic [7:0] addrs [0:9] = '{8'h00, 8'h01, 8'h10, 8'h12, 8'h20,
                                8'h21, 8'h22, 8'h30, 8'h32, 8'h05};
    logic [7:0] a;
    logic [7:0] q;
    logic [7:0] wd;

    pmsbr_regs dut_u (
        .core_clk(core_clk), .nrst(nrst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bat_below_in(bat_below_in),
        .thermal_in(thermal_in), .voltage_select_pin(voltage_select_pin),
        .pgood_in(pgood_in), .fault_in(fault_in), .battery_threshold_code(thr_code),
        .buck_one_vcode(v1), .buck_two_vcode(v2), .buck_three_vcode(v3),
        .buck_en(en), .buck_phase(ph), .irq_out(irq_out), .irq_oe(irq_oe)
    );

    pmsbr_host_model host_u (
        .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // expectations and checking
    // ----------------------------------------
    function automatic logic [7:0] exp_rd(input logic [7:0] ad);
        logic [7:0] m;
        case (ad)
            8'h00:                      m = 8'h9F;
            8'h01:                      m = 8'hBF;
            8'h12, 8'h22, 8'h32:        m = 8'h86;
            8'h10, 8'h20, 8'h21, 8'h30: m = 8'h3F;
            default:                    m = 8'h00;
        endcase
        exp_rd = shadow[ad] & m;
        if (m == 8'h86) begin
            exp_rd[0] = pgood_in[ad[5:4] - 2'd1];
        end
    endfunction : exp_rd

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("mismatches %0d num_checks %0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // status pin raised with or without unmask, then cleared by a read
    task automatic status_case(input logic [7:0] ra, input logic un);
        host_u.wr(ra, {un, 7'h00});
        shadow[ra] = {un, 7'h00};
        @(posedge core_clk);
        if (ra == 8'h00) bat_below_in <= 1'b1;
        else thermal_in <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        chk("irq_oe", {7'h00, un}, {7'h00, irq_oe});
        chk("irq_out", 8'h00, {7'h00, irq_out});
        host_u.rd(ra, q);
        chk("status", {un, 1'b1, ra == 8'h00, 5'h00}, q);
        @(posedge core_clk);
        #1;
        chk("irq_oe", 8'h00, {7'h00, irq_oe});
        host_u.rd(ra, q);
        chk("status", {un, 1'b0, ra == 8'h00, 5'h00}, q);
        @(posedge core_clk);
        bat_below_in <= 1'b0;
        thermal_in   <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : status_case

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        report_and_stop();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        bat_below_in = 1'b0;
        thermal_in = 1'b0;
        voltage_select_pin = 1'b0;
        pgood_in = 3'h0;
        fault_in = 3'h0;
        mismatches = 0;
        num_checks = 0;
        for (int i = 0; i < 256; i++) shadow[i] = 8'h00;
        void'($urandom(32'hAF12));
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        // reset values and unmapped place
        host_u.wr(8'h05, 8'hFF);
        for (int i = 0; i < 10; i++) begin
            host_u.rd(addrs[i], q);
            chk("reset", 8'h00, q);
        end
        @(posedge core_clk);
        pgood_in <= 3'($urandom);
        repeat (5) @(posedge core_clk);
        for (int i = 0; i < 60; i++) begin
            a = addrs[$urandom_range(9)];
            wd = 8'($urandom);
            host_u.wr(a, wd);
            shadow[a] = (a == 8'h05) ? 8'h00 : wd;
            host_u.rd(a, q);
            chk("rdata", exp_rd(a), q);
        end
        chk("thr", {4'h0, shadow[8'h00][3:0]}, {4'h0, thr_code});
        chk("v1", {2'h0, shadow[8'h10][5:0]}, {2'h0, v1});
        chk("v3", {2'h0, shadow[8'h30][5:0]}, {2'h0, v3});
        chk("en", {5'h00, shadow[8'h32][7], shadow[8'h22][7], shadow[8'h12][7]},
            {5'h00, en});
        chk("ph", {5'h00, shadow[8'h32][2], shadow[8'h22][2], shadow[8'h12][2]},
            {5'h00, ph});
        chk("irq_oe", 8'h00, {7'h00, irq_oe});
        // write while the clock enable is low must not land
        @(posedge core_clk);
        ce <= 1'b0;
        host_u.wr(8'h10, ~shadow[8'h10]);
        @(posedge core_clk);
        ce <= 1'b1;
        host_u.rd(8'h10, q);
        chk("ce_hold", {2'h0, shadow[8'h10][5:0]}, q);
        // dual-code select on buck two
        host_u.wr(8'h20, 8'hD5);
        host_u.wr(8'h21, 8'h2A);
        for (int s = 0; s < 2; s++) begin
            @(posedge core_clk);
            voltage_select_pin <= s[0];
            repeat (5) @(posedge core_clk);
            #1;
            chk("v2", s ? 8'h2A : 8'h15, {2'h0, v2});
        end
        status_case(8'h00, 1'b1);
        status_case(8'h00, 1'b0);
        status_case(8'h01, 1'b1);
        status_case(8'h01, 1'b0);
        // fault interrupt gating per regulator
        for (int k = 0; k < 3; k++) begin
            a = 8'h12 + 8'(k * 16);
            host_u.wr(a, 8'h02);
            @(posedge core_clk);
            fault_in <= 3'b001 << k;
            repeat (6) @(posedge core_clk);
            #1;
            chk("fault_irq", 8'h01, {7'h00, irq_oe});
            host_u.wr(a, 8'h00);
            repeat (3) @(posedge core_clk);
            #1;
            chk("fault_irq", 8'h00, {7'h00, irq_oe});
            @(posedge core_clk);
            fault_in <= 3'h0;
        end
        report_and_stop();
    end
endmodule : pmic_sys_and_buck_ctrl_regs_tb
`default_nettype wire
